// [inc/spimsp_pkg.sv]
// Constants, register map and carrier types of the serial port
package spimsp_pkg;

   // Register map, byte addresses
   localparam logic [31:0] SPIMSP_BASE       = 32'hffff0a00;
   localparam logic [4:0]  OFF_STATUS        = 5'h00;
   localparam logic [4:0]  OFF_RX            = 5'h04;
   localparam logic [4:0]  OFF_TX            = 5'h08;
   localparam logic [4:0]  OFF_DIV           = 5'h0c;
   localparam logic [4:0]  OFF_CTRL          = 5'h10;
   localparam logic [4:0]  OFF_IRQ_STAT      = 5'h14;
   localparam logic [4:0]  OFF_IRQ_MASK      = 5'h18;

   // Status fields
   localparam int          ST_TX_FULL        = 0;
   localparam int          ST_RX_AVAIL       = 1;
   localparam int          ST_BUSY           = 2;
   localparam int          ST_COUNT_LSB      = 4;
   localparam int          ST_RX_EXCESS      = 11;
   localparam logic [31:0] STATUS_RESET      = 32'h00000000;

   // Control and divider reset values
   localparam logic [6:0]  CTRL_RESET        = 7'h00;
   localparam int          DIV_WIDTH         = 8;
   localparam logic [7:0]  DIV_RESET         = 8'h00;

   // Interrupt status and mask bits
   localparam int          IRQ_BYTE_DONE     = 0;
   localparam int          IRQ_RX_OVERFLOW   = 1;
   localparam int          IRQ_RX_EXCESS     = 2;
   localparam int          IRQ_BITS          = 3;
   localparam logic [2:0]  IRQ_RESET         = 3'h0;

   // Serial framing
   localparam int          BYTE_BITS         = 8;
   localparam logic [3:0]  LAST_EDGE         = 4'hf;
   localparam logic [7:0]  IDLE_TX_BYTE      = 8'h00;

   // Pin index in the synchroniser vector
   localparam int          PIN_SCLK          = 0;
   localparam int          PIN_MOSI          = 1;
   localparam int          PIN_MISO          = 2;
   localparam int          PIN_CS            = 3;
   localparam int          PIN_COUNT         = 4;
   localparam logic [3:0]  PIN_RESET         = 4'h8;

   // Timing: reference clock and bit rate limits
   localparam int          CLK_KHZ           = 40000;
   localparam int          MASTER_MAX_KBPS   = 20000;
   localparam int          SLAVE_MAX_KBPS    = 10000;
   localparam int          MASTER_MIN_HALF   =
      (CLK_KHZ / (2 * MASTER_MAX_KBPS)) < 1 ? 1 :
      CLK_KHZ / (2 * MASTER_MAX_KBPS);
   localparam int          SLAVE_MIN_BIT     = CLK_KHZ / SLAVE_MAX_KBPS;

   // Control register layout
   typedef struct packed {
      logic [2:0] rxThresh;
      logic       cpha;
      logic       cpol;
      logic       master;
      logic       enable;
   } spimsp_ctrl_t;

   // Serial pins, one bit each
   typedef struct packed {
      logic cs;
      logic miso;
      logic mosi;
      logic sclk;
   } spimsp_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MASTER,
      ST_HOLD,
      ST_SLAVE
   } spimsp_state_t;

endpackage : spimsp_pkg

// [design/spimsp_port.sv]
// Serial peripheral port, master or slave, with APB registers
`timescale 1ns/1ps
module spimsp_port #(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt
   output logic             irq,
   // Serial clock pin
   input  wire logic        sclkIn,
   output logic             sclkOut,
   output logic             sclkOe_b,
   // Master out, slave in pin
   input  wire logic        mosiIn,
   output logic             mosiOut,
   output logic             mosiOe_b,
   // Master in, slave out pin
   input  wire logic        misoIn,
   output logic             misoOut,
   output logic             misoOe_b,
   // Chip select pin
   input  wire logic        csIn_b,
   output logic             csOut_b,
   output logic             csOe_b
);

   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);

   // Pin synchroniser
   spimsp_pkg::spimsp_pins_t pinRaw;
   logic [3:0] syncA;
   logic [3:0] syncB;
   logic [3:0] syncC;
   logic [3:0] pinF;
   logic [3:0] next_pinF;

   assign pinRaw = '{cs: csIn_b, miso: misoIn, mosi: mosiIn, sclk: sclkIn};

   // A change counts only once two late stages agree
   for (genvar i = 0; i < spimsp_pkg::PIN_COUNT; i++) begin : g_pin
      assign next_pinF[i] = (syncB[i] == syncC[i]) ? syncC[i] : pinF[i];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         syncA <= spimsp_pkg::PIN_RESET;
         syncB <= spimsp_pkg::PIN_RESET;
         syncC <= spimsp_pkg::PIN_RESET;
         pinF  <= spimsp_pkg::PIN_RESET;
      end else begin
         syncA <= pinRaw;
         syncB <= syncA;
         syncC <= syncB;
         pinF  <= next_pinF;
      end
   end

   // Registers
   spimsp_pkg::spimsp_ctrl_t ctrl;
   spimsp_pkg::spimsp_ctrl_t next_ctrl;
   logic [7:0]             divider;
   logic [7:0]             next_divider;
   logic [7:0]             txData;
   logic [7:0]             next_txData;
   logic                   txFull;
   logic                   next_txFull;
   logic [2:0]             irqStat;
   logic [2:0]             next_irqStat;
   logic [2:0]             irqMask;
   logic [2:0]             next_irqMask;
   logic [31:0]            next_prdata;

   // Receive FIFO
   logic [7:0]             rxMem [FIFO_DEPTH];
   logic [AW-1:0]          wrPtr;
   logic [AW-1:0]          next_wrPtr;
   logic [AW-1:0]          rdPtr;
   logic [AW-1:0]          next_rdPtr;
   logic [CW-1:0]          rxCount;
   logic [CW-1:0]          next_rxCount;

   // Shift engine
   spimsp_pkg::spimsp_state_t state;
   spimsp_pkg::spimsp_state_t next_state;
   logic [7:0]             divCnt;
   logic [7:0]             next_divCnt;
   logic [3:0]             edgeCnt;
   logic [3:0]             next_edgeCnt;
   logic [7:0]             txShift;
   logic [7:0]             next_txShift;
   logic [7:0]             rxShift;
   logic [7:0]             next_rxShift;
   logic                   sclkReg;
   logic                   next_sclkReg;
   logic                   csReg_b;
   logic                   next_csReg_b;
   logic                   prevSclk;
   logic                   edgeNow;
   logic                   sampleNow;
   logic                   byteDone;
   logic                   takeTx;
   logic                   rxBit;

   // Bus decode
   logic                   setupPh;
   logic                   accessPh;
   logic                   addrOk;
   logic                   wrEn;
   logic                   rdRx;
   logic                   push;
   logic                   pop;
   logic                   overflow;
   logic                   rxExcess;
   logic [31:0]            statusWord;

   assign setupPh  = psel & ~penable;
   assign accessPh = psel & penable;
   assign addrOk   = (paddr[31:5] == spimsp_pkg::SPIMSP_BASE[31:5]) &&
                     (paddr[4:0] <= spimsp_pkg::OFF_IRQ_MASK) &&
                     (paddr[1:0] == 2'h0);
   assign pready   = accessPh;
   assign pslverr  = accessPh & ~addrOk;
   assign wrEn     = accessPh & pwrite & addrOk;
   assign rdRx     = accessPh & ~pwrite & addrOk &
                     (paddr[4:0] == spimsp_pkg::OFF_RX);

   assign rxExcess = rxCount > CW'(ctrl.rxThresh);
   assign irq      = |(irqStat & irqMask);

   always_comb begin
      statusWord = spimsp_pkg::STATUS_RESET;
      statusWord[spimsp_pkg::ST_TX_FULL]   = txFull;
      statusWord[spimsp_pkg::ST_RX_AVAIL]  = rxCount != '0;
      statusWord[spimsp_pkg::ST_BUSY]      = state != spimsp_pkg::ST_IDLE;
      statusWord[spimsp_pkg::ST_COUNT_LSB +: CW] = rxCount;
      statusWord[spimsp_pkg::ST_RX_EXCESS] = rxExcess;
   end

   // Register file and read data, captured in the setup cycle
   always_comb begin
      next_ctrl    = ctrl;
      next_divider = divider;
      next_txData  = txData;
      next_irqMask = irqMask;
      next_prdata  = prdata;
      // Set beats clear: events win over a write-one-to-clear
      next_irqStat = irqStat;
      if (wrEn && paddr[4:0] == spimsp_pkg::OFF_IRQ_STAT) begin
         next_irqStat = irqStat & ~pwdata[2:0];
      end
      next_irqStat[spimsp_pkg::IRQ_BYTE_DONE]   |= byteDone;
      next_irqStat[spimsp_pkg::IRQ_RX_OVERFLOW] |= overflow;
      next_irqStat[spimsp_pkg::IRQ_RX_EXCESS]   |= rxExcess;
      // A new write wins over the engine taking the old byte
      next_txFull = txFull & ~takeTx;
      if (wrEn) begin
         case (paddr[4:0])
            spimsp_pkg::OFF_TX: begin
               next_txData = pwdata[7:0];
               next_txFull = 1'b1;
            end
            spimsp_pkg::OFF_DIV:      next_divider = pwdata[7:0];
            spimsp_pkg::OFF_CTRL:     next_ctrl    = pwdata[6:0];
            spimsp_pkg::OFF_IRQ_MASK: next_irqMask = pwdata[2:0];
            default: ;
         endcase
      end
      if (setupPh) begin
         case (paddr[4:0])
            spimsp_pkg::OFF_STATUS:   next_prdata = statusWord;
            spimsp_pkg::OFF_RX:       next_prdata = {24'h0, rxMem[rdPtr]};
            spimsp_pkg::OFF_TX:       next_prdata = {24'h0, txData};
            spimsp_pkg::OFF_DIV:      next_prdata = {24'h0, divider};
            spimsp_pkg::OFF_CTRL:     next_prdata = {25'h0, ctrl};
            spimsp_pkg::OFF_IRQ_STAT: next_prdata = {29'h0, irqStat};
            spimsp_pkg::OFF_IRQ_MASK: next_prdata = {29'h0, irqMask};
            default:                  next_prdata = 32'h0;
         endcase
      end
   end

   // FIFO pointers; a full FIFO drops the new byte
   always_comb begin
      pop          = rdRx && rxCount != '0;
      push         = byteDone && (rxCount != DEPTH_C || pop);
      overflow     = byteDone && rxCount == DEPTH_C && !pop;
      next_wrPtr   = push ? AW'(wrPtr + 1'b1) : wrPtr;
      next_rdPtr   = pop ? AW'(rdPtr + 1'b1) : rdPtr;
      next_rxCount = rxCount + CW'(push) - CW'(pop);
   end

   // Shift engine
   always_comb begin
      next_state   = state;
      next_divCnt  = divCnt;
      next_edgeCnt = edgeCnt;
      next_txShift = txShift;
      next_rxShift = rxShift;
      next_sclkReg = sclkReg;
      next_csReg_b = csReg_b;
      edgeNow      = 1'b0;
      sampleNow    = 1'b0;
      byteDone     = 1'b0;
      takeTx       = 1'b0;
      rxBit        = ctrl.master ? pinF[spimsp_pkg::PIN_MISO]
                                 : pinF[spimsp_pkg::PIN_MOSI];
      case (state)
         spimsp_pkg::ST_IDLE: begin
            next_sclkReg = ctrl.cpol;
            next_csReg_b = 1'b1;
            next_edgeCnt = 4'h0;
            next_divCnt  = 8'h00;
            if (ctrl.enable && ctrl.master && txFull) begin
               next_state   = spimsp_pkg::ST_MASTER;
               next_csReg_b = 1'b0;
               next_txShift = txData;
               takeTx       = 1'b1;
            end else if (ctrl.enable && !ctrl.master &&
                         !pinF[spimsp_pkg::PIN_CS]) begin
               next_state   = spimsp_pkg::ST_SLAVE;
               next_txShift = txFull ? txData : spimsp_pkg::IDLE_TX_BYTE;
               takeTx       = txFull;
            end
         end
         spimsp_pkg::ST_MASTER: begin
            // Half period of divider+1 reference cycles
            if (divCnt == divider) begin
               next_divCnt  = 8'h00;
               edgeNow      = 1'b1;
               next_sclkReg = ~sclkReg;
            end else begin
               next_divCnt = divCnt + 8'h01;
            end
         end
         spimsp_pkg::ST_HOLD: begin
            // Select rises a half period after the last edge
            if (divCnt == divider) begin
               next_state   = spimsp_pkg::ST_IDLE;
               next_csReg_b = 1'b1;
            end else begin
               next_divCnt = divCnt + 8'h01;
            end
         end
         spimsp_pkg::ST_SLAVE: begin
            edgeNow = pinF[spimsp_pkg::PIN_SCLK] != prevSclk;
         end
         default: next_state = spimsp_pkg::ST_IDLE;
      endcase

      if (edgeNow) begin
         // Even edges lead; phase picks which kind samples
         sampleNow = edgeCnt[0] == ctrl.cpha;
         if (sampleNow) begin
            next_rxShift = {rxShift[6:0], rxBit};
         end else if (edgeCnt != 4'h0) begin
            next_txShift = {txShift[6:0], 1'b0};
         end
         next_edgeCnt = edgeCnt + 4'h1;
         if (edgeCnt == spimsp_pkg::LAST_EDGE) begin
            byteDone = 1'b1;
            if (state == spimsp_pkg::ST_MASTER) begin
               if (txFull && ctrl.enable) begin
                  next_txShift = txData;
                  takeTx       = 1'b1;
               end else begin
                  next_state = spimsp_pkg::ST_HOLD;
               end
            end else begin
               next_txShift = txFull ? txData : spimsp_pkg::IDLE_TX_BYTE;
               takeTx       = txFull;
            end
         end
      end

      // Abort on select release or a change of role
      if (state == spimsp_pkg::ST_SLAVE &&
          (pinF[spimsp_pkg::PIN_CS] || !ctrl.enable || ctrl.master)) begin
         next_state = spimsp_pkg::ST_IDLE;
      end
      if ((state == spimsp_pkg::ST_MASTER || state == spimsp_pkg::ST_HOLD)
          && (!ctrl.enable || !ctrl.master)) begin
         next_state   = spimsp_pkg::ST_IDLE;
         next_csReg_b = 1'b1;
         next_sclkReg = ctrl.cpol;
      end
   end

   // Pin drive; enables are low while driving
   assign sclkOut  = sclkReg;
   assign csOut_b  = csReg_b;
   assign mosiOut  = txShift[7];
   assign misoOut  = txShift[7];
   assign sclkOe_b = ~(ctrl.enable & ctrl.master);
   assign csOe_b   = ~(ctrl.enable & ctrl.master);
   assign mosiOe_b = ~(ctrl.enable & ctrl.master);
   assign misoOe_b = ~(state == spimsp_pkg::ST_SLAVE);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl     <= spimsp_pkg::CTRL_RESET;
         divider  <= spimsp_pkg::DIV_RESET;
         txData   <= 8'h00;
         txFull   <= 1'b0;
         irqStat  <= spimsp_pkg::IRQ_RESET;
         irqMask  <= spimsp_pkg::IRQ_RESET;
         prdata   <= 32'h0;
         wrPtr    <= '0;
         rdPtr    <= '0;
         rxCount  <= '0;
         state    <= spimsp_pkg::ST_IDLE;
         divCnt   <= 8'h00;
         edgeCnt  <= 4'h0;
         txShift  <= 8'h00;
         rxShift  <= 8'h00;
         sclkReg  <= 1'b0;
         csReg_b  <= 1'b1;
         prevSclk <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         divider  <= next_divider;
         txData   <= next_txData;
         txFull   <= next_txFull;
         irqStat  <= next_irqStat;
         irqMask  <= next_irqMask;
         prdata   <= next_prdata;
         wrPtr    <= next_wrPtr;
         rdPtr    <= next_rdPtr;
         rxCount  <= next_rxCount;
         state    <= next_state;
         divCnt   <= next_divCnt;
         edgeCnt  <= next_edgeCnt;
         txShift  <= next_txShift;
         rxShift  <= next_rxShift;
         sclkReg  <= next_sclkReg;
         csReg_b  <= next_csReg_b;
         prevSclk <= pinF[spimsp_pkg::PIN_SCLK];
      end
   end

   // FIFO storage has no reset; the count guards every pop, but an empty read still returns rxMem[rdPtr]
   always_ff @(posedge clk) begin
      if (push) begin
         rxMem[wrPtr] <= next_rxShift;
      end
   end

endmodule : spimsp_port

// [tb/spimsp_port_sva.sv]
// Assertion checker for the serial port, bound to its top module
`timescale 1ns/1ps
module spimsp_port_sva #(
   parameter int FIFO_DEPTH = 8
) (
   // Clock, reset and APB
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Pin drives
   input wire logic        sclkOut,
   input wire logic        sclkOe_b,
   input wire logic        mosiOe_b,
   input wire logic        misoOe_b,
   input wire logic        csOut_b,
   input wire logic        csOe_b
);
   localparam logic [31:0] A_ST = spimsp_pkg::SPIMSP_BASE;
   localparam logic [31:0] A_DIV = A_ST + {27'h0, spimsp_pkg::OFF_DIV};
   localparam logic [31:0] A_CTL = A_ST + {27'h0, spimsp_pkg::OFF_CTRL};
   logic [7:0] divReg;
   logic [6:0] ctrlReg;
   logic [8:0] cnt;
   logic [7:0] edges;
   logic       prevSclk;
   logic       prevCs;
   logic       chg;
   logic       rdAcc;
   assign chg = sclkOut != prevSclk;
   assign rdAcc = psel && penable && !pwrite;
   // Shadow copies of the divider and control fields, taken at the write edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         divReg <= 8'h00;
         ctrlReg <= 7'h00;
         cnt <= 9'h000;
         edges <= 8'h00;
         prevSclk <= 1'b0;
         prevCs <= 1'b1;
      end else begin
         if (psel && penable && pwrite && paddr == A_DIV) divReg <= pwdata[7:0];
         if (psel && penable && pwrite && paddr == A_CTL) ctrlReg <= pwdata[6:0];
         cnt <= (chg || (!csOut_b && prevCs)) ? 9'h000 : cnt + 9'h001;
         edges <= (!csOut_b && prevCs) ? 8'h00 : edges + {7'h00, chg};
         prevSclk <= sclkOut;
         prevCs <= csOut_b;
      end
   end
   sequence csDrop;
      !csOe_b && !csOut_b && prevCs;
   endsequence
   sequence sclkEdge;
      sclkOut != prevSclk && !csOut_b;
   endsequence
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_MOSI_DRIVE: assert property (mosiOe_b == !(ctrlReg[0] && ctrlReg[1]))
      else $error("mosi drive differs from clock drive");
   AST_MISO_IN: assert property (!sclkOe_b |-> misoOe_b)
      else $error("miso driven in master role");
   AST_SLAVE_PINS: assert property (!misoOe_b |-> csOe_b && sclkOe_b)
      else $error("select or clock driven in slave role");
   AST_CS_FRAME: assert property (csDrop |-> ##[1:256] sclkEdge)
      else $error("no clock edge after select fell");
   AST_HALF_PERIOD: assert property ((sclkEdge and !sclkOe_b) |->
      cnt == {1'b0, divReg})
      else $error("serial clock half period wrong");
   AST_BYTE_EDGES: assert property (!csOe_b && csOut_b && !prevCs |->
      edges[3:0] == 4'h0 && edges != 8'h00)
      else $error("frame not whole bytes of sixteen edges");
   AST_EXCESS: assert property (rdAcc && paddr == A_ST |->
      prdata[11] == (prdata[7:4] > {1'b0, ctrlReg[6:4]}))
      else $error("excess flag disagrees with count");
   AST_DIV_READ: assert property (rdAcc && paddr == A_DIV |->
      prdata == {24'h0, divReg})
      else $error("divider readback wrong");
   AST_CTRL_READ: assert property (rdAcc && paddr == A_CTL |->
      prdata == {25'h0, ctrlReg})
      else $error("control readback wrong");
   AST_SCLK_IDLE: assert property (!sclkOe_b && csOut_b && prevCs &&
      $past(ctrlReg, 2) == ctrlReg |-> sclkOut == ctrlReg[2])
      else $error("idle clock level not the set polarity");
endmodule : spimsp_port_sva
bind spimsp_port spimsp_port_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
   .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .sclkOut(sclkOut), .sclkOe_b(sclkOe_b), .mosiOe_b(mosiOe_b),
   .misoOe_b(misoOe_b), .csOut_b(csOut_b), .csOe_b(csOe_b));

// [tb/spimsp_far_end.sv]
// Far end of the link: slave to the port's master, or master to it
`timescale 1ns/1ps
module spimsp_far_end #(
   parameter int HALF = 6
) (
   // Clock and setup
   input  wire logic        clk,
   input  wire logic        cpol,
   input  wire logic        cpha,
   input  wire logic        farMaster,
   input  wire logic        go,
   // Resolved pin levels
   input  wire logic        sclkW,
   input  wire logic        mosiW,
   input  wire logic        misoW,
   input  wire logic        csW_b,
   // Data
   input  wire logic [7:0]  sTx,
   input  wire logic [15:0] mTx,
   output logic      [7:0]  sRx,
   output logic      [15:0] mRx,
   output logic             done,
   // Pin drives
   output logic             fSclk,
   output logic             fMosi,
   output logic             fMiso,
   output logic             fCs_b
);
   logic run;
   logic drvSclk;
   int   ptr;
   // Clock stands at the shared idle level outside frames
   assign fSclk = run ? drvSclk : cpol;
   initial begin
      run = 1'b0;
      drvSclk = 1'b0;
      fMosi = 1'b0;
      fCs_b = 1'b1;
      done = 1'b0;
      mRx = 16'h0000;
      forever begin
         wait (go === 1'b1);
         drvSclk <= cpol;
         run <= 1'b1;
         fCs_b <= 1'b0;
         repeat (HALF + 2) @(posedge clk);
         for (int i = 15; i >= 0; i--) begin
            if (!cpha) begin
               fMosi <= mTx[i];
               repeat (HALF) @(posedge clk);
            end
            drvSclk <= ~cpol;
            if (cpha) fMosi <= mTx[i];
            else mRx[i] <= misoW;
            repeat (HALF) @(posedge clk);
            drvSclk <= cpol;
            if (cpha) mRx[i] <= misoW;
            repeat (HALF) @(posedge clk);
         end
         fCs_b <= 1'b1;
         fMosi <= ~fMosi;
         run <= 1'b0;
         done <= 1'b1;
         wait (go === 1'b0);
         done <= 1'b0;
      end
   end
   always @(negedge csW_b) begin
      ptr = cpha ? 7 : 6;
      if (!farMaster && !cpha) fMiso = sTx[7];
   end
   // Released line shows the inverse, so a stale bit cannot pass
   always @(posedge csW_b) fMiso = ~fMiso;
   always @(sclkW) begin
      if (csW_b === 1'b0 && !farMaster) begin
         if ((sclkW != cpol) != cpha) sRx = {sRx[6:0], mosiW};
         else if (ptr >= 0) begin
            fMiso = sTx[ptr];
            ptr--;
         end
      end
   end
endmodule : spimsp_far_end

// [tb/spimsp_port_tb.sv]
// Self-checking bench for the serial port
`timescale 1ns/1ps
module spimsp_port_tb;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
   logic [31:0] paddr, pwdata, prdata, rd, seed;
   logic        sclkOut, sclkOe_b, mosiOut, mosiOe_b, misoOut, misoOe_b;
   logic        csOut_b, csOe_b, fSclk, fMosi, fMiso, fCs_b, lastErr;
   logic        sclkW, mosiW, misoW, csW_b, cpol, cpha, farMaster, go, done;
   logic [7:0]  sTx, sRx;
   logic [15:0] mTx, mRx;
   int          n_errors, samples_checked, cycles;
   int          rxQ[$];
   assign sclkW = sclkOe_b ? fSclk : sclkOut;
   assign mosiW = mosiOe_b ? fMosi : mosiOut;
   assign misoW = misoOe_b ? fMiso : misoOut;
   assign csW_b = csOe_b ? fCs_b : csOut_b;
   spimsp_port #(.FIFO_DEPTH(8)) dut (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .sclkIn(sclkW), .sclkOut(sclkOut), .sclkOe_b(sclkOe_b),
      .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe_b(mosiOe_b),
      .misoIn(misoW), .misoOut(misoOut), .misoOe_b(misoOe_b),
      .csIn_b(csW_b), .csOut_b(csOut_b), .csOe_b(csOe_b));
   spimsp_far_end far (
      .clk(clk), .cpol(cpol), .cpha(cpha), .farMaster(farMaster), .go(go),
      .sclkW(sclkW), .mosiW(mosiW), .misoW(misoW), .csW_b(csW_b),
      .sTx(sTx), .mTx(mTx), .sRx(sRx), .mRx(mRx), .done(done),
      .fSclk(fSclk), .fMosi(fMosi), .fMiso(fMiso), .fCs_b(fCs_b));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic [4:0] off, input logic wr,
                      input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= spimsp_pkg::SPIMSP_BASE + {27'h0, off};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic ctrlWr(input logic [1:0] mode, input logic mst);
      // Control bit 3 is phase, bit 2 polarity
      apb(spimsp_pkg::OFF_CTRL, 1'b1,
          {25'h0, 3'h2, mode[0], mode[1], mst, 1'b1});
      cpol <= mode[1];
      cpha <= mode[0];
      farMaster <= !mst;
   endtask : ctrlWr
   // Status as the model sees it: idle engine, queue depth, threshold 2
   task automatic popAll();
      while (rxQ.size() > 0) begin
         apb(spimsp_pkg::OFF_STATUS, 1'b0, 32'h0);
         check(rd, (32'(rxQ.size()) << spimsp_pkg::ST_COUNT_LSB) |
            (32'h1 << spimsp_pkg::ST_RX_AVAIL) |
            (rxQ.size() > 2 ? 32'h1 << spimsp_pkg::ST_RX_EXCESS : 32'h0));
         apb(spimsp_pkg::OFF_RX, 1'b0, 32'h0);
         check(rd, {24'h0, 8'(rxQ.pop_front())});
      end
   endtask : popAll
   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   initial begin
      logic [7:0]  tx, div;
      logic [15:0] mt;
      int          t, low;
      {rst_b, psel, penable, pwrite, cpol, cpha, farMaster, go} = 8'h00;
      {paddr, pwdata, sTx, mTx} = 88'h0;
      {n_errors, samples_checked, cycles} = 96'h0;
      seed = 32'h0000001b;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      apb(spimsp_pkg::OFF_STATUS, 1'b0, 32'h0);
      check(rd, spimsp_pkg::STATUS_RESET);
      apb(spimsp_pkg::OFF_DIV, 1'b0, 32'h0);
      check(rd, {24'h0, spimsp_pkg::DIV_RESET});
      apb(5'h1c, 1'b0, 32'h0);
      check({31'h0, lastErr}, 32'h1);
      check(rd, 32'h0);
      for (int m = 0; m < 4; m++) begin
         // Pin sync lags four cycles, so a half period needs five
         div = 8'(32'h4 + xs() % 32'h8);
         tx = 8'(xs());
         sTx <= 8'(xs());
         apb(spimsp_pkg::OFF_DIV, 1'b1, {24'h0, div});
         ctrlWr(2'(m), 1'b1);
         rxQ.push_back(int'(sTx));
         apb(spimsp_pkg::OFF_TX, 1'b1, {24'h0, tx});
         @(negedge clk);
         t = 0;
         while (csW_b !== 1'b0 && t < 100) begin
            @(negedge clk);
            t++;
         end
         low = 0;
         while (csW_b === 1'b0 && low < 9000) begin
            @(negedge clk);
            low++;
         end
         check(32'(low), 32'(17 * (int'(div) + 1)));
         check({24'h0, sRx}, {24'h0, tx});
         @(posedge clk);
      end
      $display("master modes done");
      check({31'h0, irq}, 32'h0);
      apb(spimsp_pkg::OFF_IRQ_MASK, 1'b1, 32'h1);
      check({31'h0, irq}, 32'h1);
      apb(spimsp_pkg::OFF_IRQ_STAT, 1'b1, 32'h1);
      check({31'h0, irq}, 32'h0);
      popAll();
      $display("fifo and interrupt done");
      for (int m = 0; m < 4; m += 3) begin
         tx = 8'(xs());
         mt = 16'(xs());
         ctrlWr(2'(m), 1'b0);
         apb(spimsp_pkg::OFF_TX, 1'b1, {24'h0, tx});
         mTx <= mt;
         go <= 1'b1;
         t = 0;
         while (done !== 1'b1 && t < 2000) begin
            @(posedge clk);
            t++;
         end
         go <= 1'b0;
         // Select release crosses the pin sync before the engine idles
         repeat (6) @(posedge clk);
         check({16'h0, mRx}, {16'h0, tx, spimsp_pkg::IDLE_TX_BYTE});
         rxQ.push_back(int'(mt[15:8]));
         rxQ.push_back(int'(mt[7:0]));
         popAll();
      end
      $display("slave modes done");
      end_of_test();
   end
endmodule : spimsp_port_tb
